// ==== pt_cnt_if.sv ====
// carrier between the control logic and one reload down counter
`timescale 1ns/1ns
interface pt_cnt_if #(
  parameter int W = 8
);
  logic         tick;
  logic         load;
  logic [W-1:0] load_val;
  logic [W-1:0] count;
  logic         underflow;

  modport cnt (input tick, input load, input load_val, output count, output underflow);
  modport ctl (output tick, output load, output load_val, input count, input underflow);
endinterface

// ==== pt_down_cnt.sv ====
// reload down counter with one-cycle underflow pulse
`timescale 1ns/1ns
module pt_down_cnt #(
  parameter int W = 8
)
(
  input  wire logic clk,
  input  wire logic rst,
  pt_cnt_if.cnt     bus
);
  logic [W-1:0] reload_ff;
  logic [W-1:0] count_ff;
  logic         uf_ff;

  generate
    if (W < 2 || W > 8)
    begin : g_chk
      $error("pt_down_cnt: W must lie in 2..8");
    end
  endgenerate

  // ==================================================
  // reload register
  always_ff @(posedge clk or posedge rst)
    if (rst)
      reload_ff <= '0;
    else if (bus.load)
      reload_ff <= bus.load_val;

  // ==================================================
  // count and underflow
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      count_ff <= '0;
      uf_ff    <= 1'b0;
    end
    else
    begin
      uf_ff <= bus.tick && !bus.load && (count_ff == '0);
      if (bus.load)
        count_ff <= bus.load_val;
      else if (bus.tick)
        count_ff <= (count_ff == '0) ? reload_ff : W'(count_ff - 1'b1);
    end

  assign bus.count     = count_ff;
  assign bus.underflow = uf_ff;
endmodule

// ==== pt_edge_det.sv ====
// edge detector with polarity and both-edge selection
`timescale 1ns/1ns
module pt_edge_det (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sample,
  input  wire logic enable,
  input  wire logic falling,
  input  wire logic both,
  output logic      pulse
);
  logic prev_ff;
  logic pulse_ff;
  logic rise;
  logic fall;

  assign rise = sample & ~prev_ff;
  assign fall = ~sample & prev_ff;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      prev_ff  <= 1'b0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      prev_ff  <= sample;
      pulse_ff <= enable & (both ? (rise | fall) : (falling ? fall : rise));
    end

  assign pulse = pulse_ff;
endmodule

// ==== pt_pkg.sv ====
// types of the prescaled timer group
package pt_pkg;

  // ==================================================
  // instruction-side commands
  typedef enum logic [4:0] {
    OP_NONE,
    OP_WRITE_TIMER2_CONTROL,
    OP_WRITE_TIMER3_CONTROL,
    OP_WRITE_PIN_FUNCTION_CONTROL,
    OP_WRITE_PRESCALER_CONTROL,
    OP_WRITE_INTERRUPT_CONTROL_ONE,
    OP_WRITE_INTERRUPT_CONTROL_TWO,
    OP_WRITE_EXTERNAL_INPUT_CONTROL,
    OP_WRITE_INTERRUPT_SOURCE_SELECT,
    OP_LOAD_PRESCALER,
    OP_LOAD_TIMER2,
    OP_LOAD_TIMER3,
    OP_READ_CONTROL,
    OP_READ_COUNT,
    OP_READ_STATUS,
    OP_TEST_CLEAR_TIMER2_FLAG,
    OP_TEST_CLEAR_TIMER3_FLAG,
    OP_TEST_CLEAR_EXT1_FLAG,
    OP_TEST_CLEAR_SHARED_FLAG,
    OP_ENABLE_INTERRUPTS,
    OP_DISABLE_INTERRUPTS,
    OP_LOAD_PORT_INDEX,
    OP_SET_PORT_BIT,
    OP_CLEAR_PORT_BIT
  } pt_op_t;

  // ==================================================
  // timer 3 run control
  typedef enum logic [1:0] {
    T3_IDLE,
    T3_WAIT,
    T3_COUNT
  } pt_t3_state_t;

endpackage

// ==== pt_regs.svh ====
// field positions, reset values and timing counts of the prescaled timer group
`ifndef PT_REGS_SVH
`define PT_REGS_SVH

// ==================================================
// timing
`define PT_INSTR_DIV_M1     2'h2

// ==================================================
// field positions
`define PT_PSC_RUN_BIT      0
`define PT_T2_RUN_BIT       2
`define PT_T2_OUT_DIV2_BIT  3
`define PT_IE1_EXT1_BIT     1
`define PT_IE1_T2_BIT       3
`define PT_IE2_T3_BIT       0
`define PT_IE2_SHARED_BIT   3
`define PT_PF_CNT0_OUT_BIT  0
`define PT_EX_SYNC_BIT      0
`define PT_EX_BOTH_BIT      1
`define PT_EX_FALL_BIT      2
`define PT_EX_EN_BIT        3
`define PT_T3_RUN_BIT       2
`define PT_T3_ASTOP_BIT     3
`define PT_SS_T4_BIT        0

// ==================================================
// count source codes
`define PT_SRC_INSTR        2'h0
`define PT_SRC_PSC          2'h1
`define PT_SRC_PIN          2'h2

// ==================================================
// reset values
`define PT_CTRL_RST         4'h0
`define PT_Y_RST            4'h0

`endif

// ==== pt_timer_monitor.sv ====
// port assertions of the prescaled timer group
`timescale 1ns/1ns
module pt_timer_monitor
  import pt_pkg::*;
#(
  parameter int PORT_D_W = 10,
  parameter int CNT_W    = 8
)
(
  input wire logic                CLK_SYS,
  input wire logic                RST,
  input wire logic                CMD_VALID,
  input wire logic [4:0]          CMD_OP,
  input wire logic [7:0]          CMD_DATA,
  input wire logic                SKIP,
  input wire logic                CNTR_PIN_OE,
  input wire logic [PORT_D_W-1:0] PORT_D_O,
  input wire logic [PORT_D_W-1:0] PORT_D_OE,
  input wire logic                IRQ_TIMER2,
  input wire logic                IRQ_EXT1,
  input wire logic                IRQ_TIMER3,
  input wire logic                IRQ_SHARED
);
  // ==========
  // helper logic
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  logic pf_bit_ff;
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      pf_bit_ff <= 1'b0;
    else if (CMD_VALID && CMD_OP == OP_WRITE_PIN_FUNCTION_CONTROL)
      pf_bit_ff <= CMD_DATA[0];
  end

  // ==========
  // assertions
  property p_pf_oe;
    CMD_VALID && CMD_OP == OP_WRITE_PIN_FUNCTION_CONTROL |=> ##1 CNTR_PIN_OE == pf_bit_ff;
  endproperty
  a_pf_oe: assert property (p_pf_oe) else $error("counter pin drive mismatch");
  property p_port_od;
    PORT_D_OE == ~PORT_D_O;
  endproperty
  a_port_od: assert property (p_port_od) else $error("port drive not inverse");
  property p_skip_src;
    SKIP |-> $past(CMD_VALID) && ($past(CMD_OP) inside
      {[OP_TEST_CLEAR_TIMER2_FLAG:OP_TEST_CLEAR_SHARED_FLAG]});
  endproperty
  a_skip_src: assert property (p_skip_src) else $error("skip without test");
  property p_gie_off;
    CMD_VALID && CMD_OP == OP_DISABLE_INTERRUPTS
      |-> ##2 !(IRQ_TIMER2 || IRQ_EXT1 || IRQ_TIMER3 || IRQ_SHARED);
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("irq after disable");
  property p_t2_mask;
    CMD_VALID && CMD_OP == OP_WRITE_INTERRUPT_CONTROL_ONE && !CMD_DATA[3] |-> ##2 !IRQ_TIMER2;
  endproperty
  a_t2_mask: assert property (p_t2_mask) else $error("timer2 irq masked");
  property p_ext1_mask;
    CMD_VALID && CMD_OP == OP_WRITE_INTERRUPT_CONTROL_ONE && !CMD_DATA[1] |-> ##2 !IRQ_EXT1;
  endproperty
  a_ext1_mask: assert property (p_ext1_mask) else $error("ext1 irq masked");
  property p_t3_mask;
    CMD_VALID && CMD_OP == OP_WRITE_INTERRUPT_CONTROL_TWO && !CMD_DATA[0] |-> ##2 !IRQ_TIMER3;
  endproperty
  a_t3_mask: assert property (p_t3_mask) else $error("timer3 irq masked");
  property p_sh_mask;
    CMD_VALID && CMD_OP == OP_WRITE_INTERRUPT_CONTROL_TWO && !CMD_DATA[3] |-> ##2 !IRQ_SHARED;
  endproperty
  a_sh_mask: assert property (p_sh_mask) else $error("shared irq masked");

  c_t2: cover property ($rose(IRQ_TIMER2));
  c_skip: cover property (SKIP);
  c_t3: cover property ($rose(IRQ_TIMER3));
  c_sh: cover property ($rose(IRQ_SHARED));
endmodule

bind pt_timer_top pt_timer_monitor #(.PORT_D_W(PORT_D_W), .CNT_W(CNT_W)) u_pt_timer_monitor (
  .CLK_SYS(CLK_SYS), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
  .CMD_DATA(CMD_DATA), .SKIP(SKIP), .CNTR_PIN_OE(CNTR_PIN_OE), .PORT_D_O(PORT_D_O),
  .PORT_D_OE(PORT_D_OE), .IRQ_TIMER2(IRQ_TIMER2), .IRQ_EXT1(IRQ_EXT1),
  .IRQ_TIMER3(IRQ_TIMER3), .IRQ_SHARED(IRQ_SHARED));

// ==== pt_timer_top.sv ====
// prescaled timer group: prescaler, timers 2 and 3, counter pin, port D and request flags
// ==================================================
// Overview of operation
// - prescaler control bit 0 runs the prescaler; cleared it freezes prescaled timers
// - timer 2 control bit 2 stops or starts timer 2 down-counting from loaded value
// - interrupt control one bit 3 gates the timer 2 interrupt
// - global enable flag, set by enable and cleared by disable, masks all interrupts
// - pin function bit 0 makes counter 0 pin a timer output or an input
// - register Y indexes a port D bit; latch one releases the pin as input
// - interrupt control one bit 1 gates the external 1 interrupt
// - interrupt control two bit 0 gates the timer 3 interrupt
// - external input control bit 3 enables edge recognition on the external pin
// - bit 2 picks edge polarity, zero rising; bit 1 zero means single edge
// - external input bit 0 lets a valid external edge start timer 3
// - timer 3 control bit 3 selects the automatic count-stop circuit
// - timer 3 control bit 2 stops or starts timer 3
// - timer 3 control bits 1:0 pick count source; 01 is prescaler output
// - underflow period is sysclk times 3 times prescaler+1 times timer+1
// - timer 3 flag test, only while interrupt control two bit 0 is clear, clears the flag and skips when it was set
// - interrupt control two bit 3 gates the shared timer 4 / serial interrupt
// - source select bit 0 set picks timer 4, else serial, for shared interrupt
`timescale 1ns/1ns
`include "pt_regs.svh"
module pt_timer_top
  import pt_pkg::*;
#(
  parameter int PORT_D_W = 10,
  parameter int CNT_W    = 8
)
(
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic                CMD_VALID,
  input  wire logic [4:0]          CMD_OP,
  input  wire logic [7:0]          CMD_DATA,
  output logic      [7:0]          RD_DATA,
  output logic                     RD_VALID,
  output logic                     SKIP,
  input  wire logic                CNTR_PIN_I,
  output logic                     CNTR_PIN_O,
  output logic                     CNTR_PIN_OE,
  input  wire logic                EXT_PIN_I,
  output logic      [PORT_D_W-1:0] PORT_D_O,
  output logic      [PORT_D_W-1:0] PORT_D_OE,
  input  wire logic                T4_EVENT,
  input  wire logic                SIO_EVENT,
  input  wire logic [3:0]          IRQ_ACK,
  output logic                     IRQ_TIMER2,
  output logic                     IRQ_EXT1,
  output logic                     IRQ_TIMER3,
  output logic                     IRQ_SHARED
);

  generate
    if (PORT_D_W < 1 || PORT_D_W > 16 || CNT_W < 2 || CNT_W > 8)
    begin : g_chk
      $error("pt_timer_top: PORT_D_W must be 1..16 and CNT_W 2..8");
    end
  endgenerate

  // ==================================================
  // declarations
  pt_op_t                op;
  logic   [1:0]          div_ff;
  logic                  instr_tick_ff;
  logic   [3:0]          t2_ctl_ff;
  logic   [3:0]          t3_ctl_ff;
  logic   [3:0]          pf_ctl_ff;
  logic                  psc_run_ff;
  logic   [3:0]          ie1_ff;
  logic   [3:0]          ie2_ff;
  logic   [3:0]          ex_ctl_ff;
  logic   [3:0]          src_sel_ff;
  logic                  gie_ff;
  logic   [3:0]          y_ff;
  logic   [PORT_D_W-1:0] port_latch_ff;
  logic   [PORT_D_W-1:0] port_oe_ff;
  logic                  t2_flag_ff;
  logic                  t3_flag_ff;
  logic                  ext1_flag_ff;
  logic                  shr_flag_ff;
  pt_t3_state_t          t3_state_ff;
  pt_t3_state_t          nxt_t3_state;
  logic                  cnt0_out_ff;
  logic                  cnt0_oe_ff;
  logic   [7:0]          rd_data_ff;
  logic                  rd_valid_ff;
  logic                  skip_ff;
  logic                  irq_t2_ff;
  logic                  irq_ext1_ff;
  logic                  irq_t3_ff;
  logic                  irq_shr_ff;
  logic                  pin_edge;
  logic                  ext_edge;
  logic                  tst_t2;
  logic                  tst_t3;
  logic                  tst_ext1;
  logic                  tst_shr;
  logic                  shr_event;

  pt_cnt_if #(.W(CNT_W)) psc_bus ();
  pt_cnt_if #(.W(CNT_W)) t2_bus ();
  pt_cnt_if #(.W(CNT_W)) t3_bus ();

  assign op = CMD_VALID ? pt_op_t'(CMD_OP) : OP_NONE;

  function automatic logic src_tick(
    input logic [1:0] src,
    input logic       instr,
    input logic       psc,
    input logic       pin
  );
    case (src)
      `PT_SRC_INSTR: src_tick = instr;
      `PT_SRC_PSC:   src_tick = psc;
      `PT_SRC_PIN:   src_tick = pin;
      default:       src_tick = 1'b0;
    endcase
  endfunction

  // ==================================================
  // instruction clock: system clock divided by three
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      div_ff        <= 2'h0;
      instr_tick_ff <= 1'b0;
    end
    else
    begin
      div_ff        <= (div_ff == `PT_INSTR_DIV_M1) ? 2'h0 : 2'(div_ff + 2'h1);
      instr_tick_ff <= (div_ff == `PT_INSTR_DIV_M1);
    end

  // ==================================================
  // counters
  assign psc_bus.tick     = instr_tick_ff & psc_run_ff;
  assign psc_bus.load     = (op == OP_LOAD_PRESCALER);
  assign psc_bus.load_val = CMD_DATA[CNT_W-1:0];

  assign t2_bus.tick      = t2_ctl_ff[`PT_T2_RUN_BIT] &
                            src_tick(t2_ctl_ff[1:0], instr_tick_ff, psc_bus.underflow, pin_edge);
  assign t2_bus.load      = (op == OP_LOAD_TIMER2);
  assign t2_bus.load_val  = CMD_DATA[CNT_W-1:0];

  assign t3_bus.tick      = (t3_state_ff == T3_COUNT) &
                            src_tick(t3_ctl_ff[1:0], instr_tick_ff, psc_bus.underflow, pin_edge);
  assign t3_bus.load      = (op == OP_LOAD_TIMER3);
  assign t3_bus.load_val  = CMD_DATA[CNT_W-1:0];

  pt_down_cnt #(.W(CNT_W)) u_psc (.clk(CLK_SYS), .rst(RST), .bus(psc_bus.cnt));
  pt_down_cnt #(.W(CNT_W)) u_t2  (.clk(CLK_SYS), .rst(RST), .bus(t2_bus.cnt));
  pt_down_cnt #(.W(CNT_W)) u_t3  (.clk(CLK_SYS), .rst(RST), .bus(t3_bus.cnt));

  // ==================================================
  // edge detection
  pt_edge_det u_pin_edge (
    .clk     (CLK_SYS),
    .rst     (RST),
    .sample  (CNTR_PIN_I),
    .enable  (~pf_ctl_ff[`PT_PF_CNT0_OUT_BIT]),
    .falling (1'b0),
    .both    (1'b0),
    .pulse   (pin_edge)
  );

  pt_edge_det u_ext_edge (
    .clk     (CLK_SYS),
    .rst     (RST),
    .sample  (EXT_PIN_I),
    .enable  (ex_ctl_ff[`PT_EX_EN_BIT]),
    .falling (ex_ctl_ff[`PT_EX_FALL_BIT]),
    .both    (ex_ctl_ff[`PT_EX_BOTH_BIT]),
    .pulse   (ext_edge)
  );

  // ==================================================
  // control registers
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      t2_ctl_ff  <= `PT_CTRL_RST;
      t3_ctl_ff  <= `PT_CTRL_RST;
      pf_ctl_ff  <= `PT_CTRL_RST;
      psc_run_ff <= 1'b0;
      ie1_ff     <= `PT_CTRL_RST;
      ie2_ff     <= `PT_CTRL_RST;
      ex_ctl_ff  <= `PT_CTRL_RST;
      src_sel_ff <= `PT_CTRL_RST;
    end
    else
    begin
      case (op)
        OP_WRITE_TIMER2_CONTROL:          t2_ctl_ff  <= CMD_DATA[3:0];
        OP_WRITE_TIMER3_CONTROL:          t3_ctl_ff  <= CMD_DATA[3:0];
        OP_WRITE_PIN_FUNCTION_CONTROL:    pf_ctl_ff  <= CMD_DATA[3:0];
        OP_WRITE_PRESCALER_CONTROL:       psc_run_ff <= CMD_DATA[`PT_PSC_RUN_BIT];
        OP_WRITE_INTERRUPT_CONTROL_ONE:   ie1_ff     <= CMD_DATA[3:0];
        OP_WRITE_INTERRUPT_CONTROL_TWO:   ie2_ff     <= CMD_DATA[3:0];
        OP_WRITE_EXTERNAL_INPUT_CONTROL:  ex_ctl_ff  <= CMD_DATA[3:0];
        OP_WRITE_INTERRUPT_SOURCE_SELECT: src_sel_ff <= CMD_DATA[3:0];
        default:                          ;
      endcase
    end

  // global interrupt enable
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      gie_ff <= 1'b0;
    else if (op == OP_ENABLE_INTERRUPTS)
      gie_ff <= 1'b1;
    else if (op == OP_DISABLE_INTERRUPTS)
      gie_ff <= 1'b0;

  // ==================================================
  // timer 3 run control
  always_comb
  begin
    nxt_t3_state = t3_state_ff;
    if (!t3_ctl_ff[`PT_T3_RUN_BIT])
      nxt_t3_state = T3_IDLE;
    else
    begin
      case (t3_state_ff)
        T3_IDLE:
          nxt_t3_state = ex_ctl_ff[`PT_EX_SYNC_BIT] ? T3_WAIT : T3_COUNT;
        T3_WAIT:
          if (ext_edge || (!ex_ctl_ff[`PT_EX_SYNC_BIT] && !t3_ctl_ff[`PT_T3_ASTOP_BIT]))
            nxt_t3_state = T3_COUNT;
        T3_COUNT:
          if (t3_bus.underflow && t3_ctl_ff[`PT_T3_ASTOP_BIT])
            nxt_t3_state = T3_WAIT;
        default:
          nxt_t3_state = T3_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      t3_state_ff <= T3_IDLE;
    else
      t3_state_ff <= nxt_t3_state;

  // ==================================================
  // request flags and skip tests; a set wins over a clear
  assign tst_t2    = (op == OP_TEST_CLEAR_TIMER2_FLAG) && !ie1_ff[`PT_IE1_T2_BIT];
  assign tst_t3    = (op == OP_TEST_CLEAR_TIMER3_FLAG) && !ie2_ff[`PT_IE2_T3_BIT];
  assign tst_ext1  = (op == OP_TEST_CLEAR_EXT1_FLAG) && !ie1_ff[`PT_IE1_EXT1_BIT];
  assign tst_shr   = (op == OP_TEST_CLEAR_SHARED_FLAG) && !ie2_ff[`PT_IE2_SHARED_BIT];
  assign shr_event = src_sel_ff[`PT_SS_T4_BIT] ? T4_EVENT : SIO_EVENT;

  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      t2_flag_ff   <= 1'b0;
      t3_flag_ff   <= 1'b0;
      ext1_flag_ff <= 1'b0;
      shr_flag_ff  <= 1'b0;
      skip_ff      <= 1'b0;
    end
    else
    begin
      t2_flag_ff   <= t2_bus.underflow | (t2_flag_ff & ~(tst_t2 | IRQ_ACK[0]));
      ext1_flag_ff <= ext_edge | (ext1_flag_ff & ~(tst_ext1 | IRQ_ACK[1]));
      t3_flag_ff   <= t3_bus.underflow | (t3_flag_ff & ~(tst_t3 | IRQ_ACK[2]));
      shr_flag_ff  <= shr_event | (shr_flag_ff & ~(tst_shr | IRQ_ACK[3]));
      skip_ff      <= (tst_t2 & t2_flag_ff) | (tst_t3 & t3_flag_ff) |
                      (tst_ext1 & ext1_flag_ff) | (tst_shr & shr_flag_ff);
    end

  // ==================================================
  // interrupt requests
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      irq_t2_ff   <= 1'b0;
      irq_ext1_ff <= 1'b0;
      irq_t3_ff   <= 1'b0;
      irq_shr_ff  <= 1'b0;
    end
    else
    begin
      irq_t2_ff   <= gie_ff & ie1_ff[`PT_IE1_T2_BIT] & t2_flag_ff;
      irq_ext1_ff <= gie_ff & ie1_ff[`PT_IE1_EXT1_BIT] & ext1_flag_ff;
      irq_t3_ff   <= gie_ff & ie2_ff[`PT_IE2_T3_BIT] & t3_flag_ff;
      irq_shr_ff  <= gie_ff & ie2_ff[`PT_IE2_SHARED_BIT] & shr_flag_ff;
    end

  // ==================================================
  // counter 0 pin
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      cnt0_out_ff <= 1'b0;
      cnt0_oe_ff  <= 1'b0;
    end
    else
    begin
      cnt0_oe_ff <= pf_ctl_ff[`PT_PF_CNT0_OUT_BIT];
      if (!t2_ctl_ff[`PT_T2_OUT_DIV2_BIT])
        cnt0_out_ff <= 1'b0;
      else if (t2_bus.underflow)
        cnt0_out_ff <= ~cnt0_out_ff;
    end

  // ==================================================
  // port D bit access
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      y_ff <= `PT_Y_RST;
    else if (op == OP_LOAD_PORT_INDEX)
      y_ff <= CMD_DATA[3:0];

  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      port_latch_ff <= '1;
      port_oe_ff    <= '0;
    end
    else if ((op == OP_SET_PORT_BIT || op == OP_CLEAR_PORT_BIT) && (y_ff < PORT_D_W))
    begin
      port_latch_ff[y_ff] <= (op == OP_SET_PORT_BIT);
      port_oe_ff[y_ff]    <= (op == OP_CLEAR_PORT_BIT);
    end

  // ==================================================
  // read-back
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
    begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= (op == OP_READ_CONTROL) || (op == OP_READ_COUNT) || (op == OP_READ_STATUS);
      case (op)
        OP_READ_CONTROL:
          case (CMD_DATA[2:0])
            3'h0:    rd_data_ff <= {4'h0, t2_ctl_ff};
            3'h1:    rd_data_ff <= {4'h0, t3_ctl_ff};
            3'h2:    rd_data_ff <= {4'h0, pf_ctl_ff};
            3'h3:    rd_data_ff <= {7'h00, psc_run_ff};
            3'h4:    rd_data_ff <= {4'h0, ie1_ff};
            3'h5:    rd_data_ff <= {4'h0, ie2_ff};
            3'h6:    rd_data_ff <= {4'h0, ex_ctl_ff};
            default: rd_data_ff <= {4'h0, src_sel_ff};
          endcase
        OP_READ_COUNT:
          case (CMD_DATA[1:0])
            2'h0:    rd_data_ff <= 8'(psc_bus.count);
            2'h1:    rd_data_ff <= 8'(t2_bus.count);
            2'h2:    rd_data_ff <= 8'(t3_bus.count);
            default: rd_data_ff <= 8'h00;
          endcase
        OP_READ_STATUS:
          rd_data_ff <= {(t3_state_ff == T3_COUNT), (t3_state_ff == T3_WAIT), 1'b0, gie_ff,
                         shr_flag_ff, t3_flag_ff, ext1_flag_ff, t2_flag_ff};
        default:
          ;
      endcase
    end

  // ==================================================
  // outputs
  assign RD_DATA     = rd_data_ff;
  assign RD_VALID    = rd_valid_ff;
  assign SKIP        = skip_ff;
  assign CNTR_PIN_O  = cnt0_out_ff;
  assign CNTR_PIN_OE = cnt0_oe_ff;
  assign PORT_D_O    = port_latch_ff;
  assign PORT_D_OE   = port_oe_ff;
  assign IRQ_TIMER2  = irq_t2_ff;
  assign IRQ_EXT1    = irq_ext1_ff;
  assign IRQ_TIMER3  = irq_t3_ff;
  assign IRQ_SHARED  = irq_shr_ff;
endmodule

// ==== tb.sv ====
// self-checking bench of the prescaled timer group
`timescale 1ns/1ns
module tb;
  import pt_pkg::*;
  // ==========
  // signals
  logic       clk_sys   = 1'b0;
  logic       rst       = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [4:0] cmd_op    = 5'h00;
  logic [7:0] cmd_data  = 8'h00;
  logic       ext_pin   = 1'b0;
  logic       cntr_in   = 1'b0;
  logic [1:0] ev        = 2'h0;
  logic [3:0] irq_ack   = 4'h0;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       skip;
  logic       cntr_oe;
  logic       cntr_o;
  logic [9:0] pd_o;
  logic [9:0] pd_oe;
  logic [3:0] irq;
  logic [7:0] d;
  int         errors      = 0;
  int         comparisons = 0;
  int         seed        = 32'h610883C2;
  int         cyc         = 0;
  int         mdl [8];
  int         lat;
  int         r;
  int         t0;
  pt_op_t     wop [8] = '{OP_WRITE_TIMER2_CONTROL, OP_WRITE_TIMER3_CONTROL,
    OP_WRITE_PIN_FUNCTION_CONTROL, OP_WRITE_PRESCALER_CONTROL, OP_WRITE_INTERRUPT_CONTROL_ONE,
    OP_WRITE_INTERRUPT_CONTROL_TWO, OP_WRITE_EXTERNAL_INPUT_CONTROL,
    OP_WRITE_INTERRUPT_SOURCE_SELECT};

  pt_timer_top u_pt_timer_top (.CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .SKIP(skip), .CNTR_PIN_I(cntr_in), .CNTR_PIN_O(cntr_o), .CNTR_PIN_OE(cntr_oe),
    .EXT_PIN_I(ext_pin), .PORT_D_O(pd_o), .PORT_D_OE(pd_oe), .T4_EVENT(ev[1]),
    .SIO_EVENT(ev[0]), .IRQ_ACK(irq_ack), .IRQ_TIMER2(irq[0]), .IRQ_EXT1(irq[1]),
    .IRQ_TIMER3(irq[2]), .IRQ_SHARED(irq[3]));

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ==========
  // tasks
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic timeout;
    errors++;
    $display("unexpected at %0t: wait bound used up", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input pt_op_t op, input logic [7:0] v);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = v;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input pt_op_t op, input logic [7:0] sel);
    cmd(op, sel);
    chk(16'(rd_valid), 16'h0001, "read strobe");
    d = rd_data;
  endtask
  task automatic ack(input logic [3:0] m);
    @(negedge clk_sys);
    irq_ack = m;
    @(negedge clk_sys);
    irq_ack = 4'h0;
  endtask
  task automatic pulse(input logic [1:0] m);
    @(negedge clk_sys);
    ev = m;
    @(negedge clk_sys);
    ev = 2'h0;
  endtask
  task automatic wait_irq(input int b, input logic lvl);
    int n;
    n = 0;
    while (irq[b] !== lvl)
    begin
      @(negedge clk_sys);
      n++;
      if (n > 500)
        timeout();
    end
  endtask
  task automatic hold(input int b, input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (irq[b] !== 1'b0)
        c++;
    end
    chk(16'(c), 16'h0000, "irq held");
  endtask

  // ==========
  // scenarios
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    lat = 1023;
    for (int s = 0; s < 8; s++)
    begin
      r = $random(seed);
      if (s < 2)
        r = r & 32'hFFFFFFFB;
      mdl[s] = r & ((s == 3) ? 1 : 15);
      cmd(wop[s], r[7:0]);
    end
    cmd(pt_op_t'(5'h1F), 8'hFF);
    for (int s = 0; s < 8; s++)
    begin
      rd(OP_READ_CONTROL, 8'(s));
      chk(16'(d), 16'(mdl[s]), "control readback");
    end
    chk(16'(cntr_oe), 16'(mdl[2] & 1), "counter pin drive");
    for (int s = 0; s < 8; s++)
      cmd(wop[s], 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      cmd(OP_LOAD_PORT_INDEX, 8'(i));
      cmd(OP_CLEAR_PORT_BIT, 8'h00);
      chk(16'(pd_o), 16'((i < 10) ? (lat & ~(1 << i)) : lat), "port clear");
      cmd(OP_SET_PORT_BIT, 8'h00);
      chk(16'(pd_oe), 16'h0000, "port released");
    end
    cmd(OP_LOAD_PRESCALER, 8'h02);
    cmd(OP_LOAD_TIMER2, 8'h03);
    cmd(OP_WRITE_INTERRUPT_CONTROL_ONE, 8'h08);
    cmd(OP_ENABLE_INTERRUPTS, 8'h00);
    cmd(OP_WRITE_TIMER2_CONTROL, 8'h05);
    cmd(OP_WRITE_PRESCALER_CONTROL, 8'h01);
    wait_irq(0, 1'b1);
    t0 = cyc;
    ack(4'h1);
    wait_irq(0, 1'b0);
    wait_irq(0, 1'b1);
    chk(16'(cyc - t0), 16'(3 * 3 * 4), "timer2 period");
    cmd(OP_WRITE_INTERRUPT_CONTROL_ONE, 8'h00);
    hold(0, 80);
    cmd(OP_WRITE_INTERRUPT_CONTROL_ONE, 8'h08);
    wait_irq(0, 1'b1);
    cmd(OP_DISABLE_INTERRUPTS, 8'h00);
    hold(0, 80);
    cmd(OP_ENABLE_INTERRUPTS, 8'h00);
    wait_irq(0, 1'b1);
    cmd(OP_WRITE_PRESCALER_CONTROL, 8'h00);
    repeat (3) @(negedge clk_sys);
    ack(4'h1);
    hold(0, 100);
    cmd(OP_WRITE_TIMER2_CONTROL, 8'h01);
    cmd(OP_WRITE_PRESCALER_CONTROL, 8'h01);
    hold(0, 100);
    cmd(OP_LOAD_TIMER2, 8'h00);
    cmd(OP_WRITE_TIMER2_CONTROL, 8'h0E);
    cntr_in = 1'b1;
    wait_irq(0, 1'b1);
    chk(16'(cntr_o), 16'h0001, "counter pin toggle");
    cmd(OP_LOAD_PRESCALER, 8'h00);
    cmd(OP_LOAD_TIMER3, 8'h02);
    cmd(OP_WRITE_EXTERNAL_INPUT_CONTROL, 8'h09);
    cmd(OP_WRITE_TIMER3_CONTROL, 8'h0D);
    rd(OP_READ_STATUS, 8'h00);
    chk(16'(d[7:6]), 16'h0001, "timer3 armed");
    ext_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(OP_READ_STATUS, 8'h00);
    chk(16'(d[7:6]), 16'h0002, "timer3 started");
    chk(16'(d[1]), 16'h0001, "ext flag");
    for (int k = 0; k < 40 && d[2] !== 1'b1; k++)
      rd(OP_READ_STATUS, 8'h00);
    if (d[2] !== 1'b1)
      timeout();
    chk(16'(d[7:6]), 16'h0001, "timer3 auto stop");
    cmd(OP_TEST_CLEAR_TIMER3_FLAG, 8'h00);
    chk(16'(skip), 16'h0001, "test skip");
    cmd(OP_TEST_CLEAR_TIMER3_FLAG, 8'h00);
    chk(16'(skip), 16'h0000, "test cleared");
    repeat (40) @(negedge clk_sys);
    rd(OP_READ_STATUS, 8'h00);
    chk(16'({d[7:6], d[2]}), 16'h0002, "timer3 stays stopped");
    cmd(OP_WRITE_INTERRUPT_CONTROL_TWO, 8'h01);
    ext_pin = 1'b0;
    repeat (3) @(negedge clk_sys);
    ext_pin = 1'b1;
    wait_irq(2, 1'b1);
    ext_pin = 1'b0;
    cmd(OP_WRITE_EXTERNAL_INPUT_CONTROL, 8'h00);
    cmd(OP_WRITE_INTERRUPT_CONTROL_ONE, 8'h02);
    ack(4'h2);
    ext_pin = 1'b1;
    hold(1, 20);
    ext_pin = 1'b0;
    cmd(OP_WRITE_EXTERNAL_INPUT_CONTROL, 8'h0C);
    ext_pin = 1'b1;
    hold(1, 20);
    ext_pin = 1'b0;
    wait_irq(1, 1'b1);
    cmd(OP_WRITE_INTERRUPT_SOURCE_SELECT, 8'h01);
    cmd(OP_WRITE_INTERRUPT_CONTROL_TWO, 8'h08);
    pulse(2'h1);
    hold(3, 20);
    pulse(2'h2);
    wait_irq(3, 1'b1);
    cmd(OP_WRITE_INTERRUPT_CONTROL_TWO, 8'h00);
    hold(3, 20);
    print_verdict();
  end
endmodule
